// ==== verilog/setpoint_consts.svh ====
`ifndef SETPOINT_CONSTS_SVH
`define SETPOINT_CONSTS_SVH

// ***************************************************
// register offsets
// ***************************************************
`define OFS_MODE        12'h000
`define OFS_RANGE       12'h004
`define OFS_SP_LOW      12'h008
`define OFS_SP_HIGH     12'h00C
`define OFS_CONFIG      12'h010
`define OFS_CONTACT     12'h014
`define OFS_STATUS      12'h018
`define OFS_WORKING     12'h01C
`define OFS_LOCAL_SP    12'h020
`define OFS_RAMP_RATE   12'h024
`define OFS_RESTORE     12'h028
`define OFS_STEP_BASE   12'h080

// ***************************************************
// field positions in the config register
// ***************************************************
`define CFG_TYPE_LSB    0
`define CFG_UNIT_LSB    2
`define CFG_SOAKU_LSB   4
`define CFG_END_LSB     6
`define CFG_COUNT_LSB   8

// ***************************************************
// codes and reset values
// ***************************************************
`define RAMP_CTL_CODE   5'h0D
`define CONTACT_RESET   5'h00
`define TYPE_RESET      2'h0
`define UNIT_RESET      2'h1
`define SOAKU_RESET     2'h0
`define END_RESET       2'h0
`define COUNT_RESET     4'h1
`define GAIN_RESET      4'h1

// ***************************************************
// timing
// ***************************************************
`define TENTH_NS        100000000
`define CLK_NS          50
`define TENTHS_PER_SEC  16'd10
`define TENTHS_PER_MIN  16'd600
`define TENTHS_PER_HOUR 16'd36000

`endif

// ==== verilog/setpoint_pkg.sv ====
package setpoint_pkg;
   typedef enum logic [1:0] {st_ready, st_ramp, st_soak, st_hold} prog_state_t;
   typedef logic signed [15:0] sp_t;
   typedef logic signed [19:0] sp_fine_t;
endpackage

// ==== verilog/setpoint_step_sequencer.sv ====
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "setpoint_consts.svh"

// Overview of operation
// [RL1] working setpoint stays between the limits
// [RL2] inverted limits are swapped silently
// [RL3] range type write reloads both limits
// [RL4] contact selectors: 13 ramp control, reset 0
// [RL5] contact off enables ramp, on disables
// [RL6] software assigns ramp control to one contact
// [RL7] ramp disabled: setpoint jumps to target
// [RL8] eight steps: target, rate, soak, gain
// [RL9] each step ramps then soaks
// [RL10] program advances only in RUN mode
// [RL11] step count 1 to 8, reset 1
// [RL12] ramp type: standard, multi, program
// [RL13] type 2 power return: READY, step 1
// [RL14] type 3 soak loss resumes soak start
// [RL15] type 3 ramp loss restarts from process value
// [RL16] type 3 ramp loss with alarm skips to soak
// [RL17] type 3 run stores progress each phase change
// [RL18] switching to program type in RUN forces READY
// [RL19] program enabled forces local setpoint
// [RL20] ramp unit per second, minute, hour
// [RL21] ramp resolution one digit finer
// [RL22] soak unit tenth second, second, minute
// [RL23] program end: ready, loop or hold
// [RL24] soak expiry advances to next step ramp
// [RL25] zero rate completes ramp immediately
module setpoint_step_sequencer
   import setpoint_pkg::*;
#(
   parameter int TENTH_CYCLES = `TENTH_NS / `CLK_NS
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire sp_t         process_value,
   input  wire sp_t         range_low,
   input  wire sp_t         range_high,
   input  wire logic [4:0]  contact_input,
   input  wire logic        input_alarm,
   input  wire logic        nvm_saved_running,
   input  wire logic [2:0]  nvm_saved_step,
   input  wire logic        nvm_saved_soak,
   output      sp_fine_t    working_setpoint,
   output      logic [3:0]  active_gain_set,
   output      logic        remote_select,
   output      logic        nvm_write,
   output      logic [2:0]  nvm_step,
   output      logic        nvm_soak
);

   // ***************************************************
   // helpers
   // ***************************************************
   // setpoints carry one more decimal internally than the process value
   function automatic sp_fine_t to_fine(input sp_t v);
      sp_fine_t x;
      x = {{4{v[15]}}, v};
      return (x <<< 3) + (x <<< 1); // [RL21]
   endfunction

   function automatic sp_t clamp(input sp_t v, input sp_t lo, input sp_t hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // ***************************************************
   // registers
   // ***************************************************
   sp_t         sp_low;
   sp_t         sp_high;
   sp_t         local_sp;
   logic [15:0] ramp_rate;
   logic [7:0]  input_range_type;
   logic [1:0]  ramp_type_setting;
   logic [1:0]  ramp_unit_setting;
   logic [1:0]  soak_time_unit;
   logic [1:0]  program_end_action;
   logic [3:0]  step_count_setting;
   logic [4:0]  contact_fn [0:4];
   logic        remote_request;
   sp_t         step_target [0:7];
   logic [15:0] step_rate   [0:7];
   logic [15:0] step_soak   [0:7];
   logic [3:0]  step_gain   [0:7];

   prog_state_t state;
   prog_state_t next_state;
   logic [2:0]  step;
   logic [2:0]  next_step;
   sp_fine_t    sp_acc;
   sp_fine_t    next_sp;
   logic [15:0] soak_cnt;
   logic [15:0] next_soak;
   logic [15:0] pre_cnt;
   logic [15:0] next_pre;
   logic        run;
   logic        next_run;
   logic        nvm_evt;
   logic [31:0] tenth_cnt;
   logic [4:0]  contact_meta;
   logic [4:0]  contact_sync;
   logic        alarm_meta;
   logic        alarm_sync;
   logic [4:0]  nvm_meta;
   logic [4:0]  nvm_sync;
   logic [31:0] rd_mux;

   // ***************************************************
   // bus decode
   // ***************************************************
   wire         setup_rd    = psel && !penable && !pwrite;
   wire         wr          = psel && penable && pwrite;
   wire         in_steps    = paddr[11:7] == 5'(`OFS_STEP_BASE >> 7);
   wire [2:0]   wsel_step   = paddr[6:4];
   wire [1:0]   wsel_field  = paddr[3:2];
   wire         wr_mode     = wr && paddr == `OFS_MODE;
   wire         wr_range    = wr && paddr == `OFS_RANGE;
   wire         wr_cfg      = wr && paddr == `OFS_CONFIG;
   wire         wr_restore  = wr && paddr == `OFS_RESTORE && pwdata[0];
   wire         any_wr      = wr;
   wire [1:0]   new_type    = pwdata[`CFG_TYPE_LSB +: 2];
   wire [3:0]   new_count   = pwdata[`CFG_COUNT_LSB +: 4];
   wire         mapped      = in_steps || paddr == `OFS_MODE || paddr == `OFS_RANGE
                              || paddr == `OFS_SP_LOW || paddr == `OFS_SP_HIGH
                              || paddr == `OFS_CONFIG || paddr == `OFS_CONTACT
                              || paddr == `OFS_STATUS || paddr == `OFS_WORKING
                              || paddr == `OFS_LOCAL_SP || paddr == `OFS_RAMP_RATE
                              || paddr == `OFS_RESTORE;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ***************************************************
   // derived controls
   // ***************************************************
   wire         program_en  = ramp_type_setting[1]; // [RL12]
   wire sp_t    lo          = (sp_low > sp_high) ? sp_high : sp_low; // [RL2]
   wire sp_t    hi          = (sp_low > sp_high) ? sp_low : sp_high; // [RL2]
   wire sp_fine_t lo_f      = to_fine(lo);
   wire sp_fine_t hi_f      = to_fine(hi);
   wire sp_t    raw_tgt     = program_en ? step_target[step] : local_sp;
   wire sp_fine_t tgt_fine  = to_fine(clamp(raw_tgt, lo, hi)); // [RL1]
   wire [15:0]  cur_rate    = program_en ? step_rate[step] : ramp_rate;
   wire [15:0]  cur_soak    = step_soak[step];
   wire [4:0]   fn_ramp;
   wire         ramp_off    = |(fn_ramp & contact_sync); // [RL5]

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_fn
         assign fn_ramp[gi] = contact_fn[gi] == `RAMP_CTL_CODE; // [RL4]
      end
   endgenerate

   wire         tenth_tick  = tenth_cnt == 32'(TENTH_CYCLES - 1);
   wire [15:0]  ramp_len    = (ramp_unit_setting == 2'h0) ? `TENTHS_PER_SEC :
                              (ramp_unit_setting == 2'h1) ? `TENTHS_PER_MIN : `TENTHS_PER_HOUR; // [RL20]
   wire [15:0]  soak_len    = (soak_time_unit == 2'h0) ? 16'h0001 :
                              (soak_time_unit == 2'h1) ? `TENTHS_PER_SEC : `TENTHS_PER_MIN; // [RL22]
   wire         ramp_tick   = tenth_tick && (pre_cnt + 16'h0001 >= ramp_len);
   wire         soak_tick   = tenth_tick && (pre_cnt + 16'h0001 >= soak_len);
   wire sp_fine_t rate_f    = {4'h0, cur_rate};
   wire sp_fine_t up_sum    = sp_acc + rate_f;
   wire sp_fine_t dn_sum    = sp_acc - rate_f;
   wire sp_fine_t ramp_next = (sp_acc < tgt_fine) ? ((up_sum > tgt_fine) ? tgt_fine : up_sum)
                                                  : ((dn_sum < tgt_fine) ? tgt_fine : dn_sum);
   wire         last_step   = {1'b0, step} + 4'h1 >= step_count_setting; // [RL11]
   wire sp_fine_t out_sp    = (next_sp < lo_f) ? lo_f : ((next_sp > hi_f) ? hi_f : next_sp);

   // ***************************************************
   // register file writes
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sp_low             <= '0;
         sp_high            <= '0;
         local_sp           <= '0;
         ramp_rate          <= '0;
         input_range_type   <= '0;
         ramp_type_setting  <= `TYPE_RESET;
         ramp_unit_setting  <= `UNIT_RESET;
         soak_time_unit     <= `SOAKU_RESET;
         program_end_action <= `END_RESET;
         step_count_setting <= `COUNT_RESET;
         remote_request     <= 1'b0;
         for (int i = 0; i < 5; i++)
            contact_fn[i] <= `CONTACT_RESET; // [RL4]
         for (int i = 0; i < 8; i++)
         begin
            step_target[i] <= '0;
            step_rate[i]   <= '0;
            step_soak[i]   <= '0;
            step_gain[i]   <= `GAIN_RESET;
         end
      end
      else if (wr)
      begin
         if (wr_range)
         begin
            input_range_type <= pwdata[7:0];
            sp_low           <= range_low; // [RL3]
            sp_high          <= range_high; // [RL3]
         end
         else if (paddr == `OFS_MODE)
            remote_request <= pwdata[1];
         else if (paddr == `OFS_SP_LOW)
            sp_low <= pwdata[15:0];
         else if (paddr == `OFS_SP_HIGH)
            sp_high <= pwdata[15:0];
         else if (paddr == `OFS_LOCAL_SP)
            local_sp <= pwdata[15:0];
         else if (paddr == `OFS_RAMP_RATE)
            ramp_rate <= pwdata[15:0];
         else if (wr_cfg)
         begin
            ramp_type_setting  <= new_type; // [RL12]
            ramp_unit_setting  <= (pwdata[`CFG_UNIT_LSB +: 2] == 2'h3) ? ramp_unit_setting
                                  : pwdata[`CFG_UNIT_LSB +: 2];
            soak_time_unit     <= (pwdata[`CFG_SOAKU_LSB +: 2] == 2'h3) ? soak_time_unit
                                  : pwdata[`CFG_SOAKU_LSB +: 2];
            program_end_action <= (pwdata[`CFG_END_LSB +: 2] == 2'h3) ? program_end_action
                                  : pwdata[`CFG_END_LSB +: 2];
            // out-of-range counts keep the old value rather than wrapping
            if (new_count >= 4'h1 && new_count <= 4'h8)
               step_count_setting <= new_count; // [RL11]
         end
         else if (paddr == `OFS_CONTACT)
         begin
            for (int i = 0; i < 5; i++)
               contact_fn[i] <= pwdata[i*5 +: 5];
         end
         else if (in_steps)
         begin
            if (wsel_field == 2'h0)
               step_target[wsel_step] <= pwdata[15:0]; // [RL8]
            else if (wsel_field == 2'h1)
               step_rate[wsel_step] <= pwdata[15:0];
            else if (wsel_field == 2'h2)
               step_soak[wsel_step] <= pwdata[15:0];
            else if (pwdata[3:0] >= 4'h1 && pwdata[3:0] <= 4'h8)
               step_gain[wsel_step] <= pwdata[3:0];
         end
      end
   end

   // ***************************************************
   // program engine
   // ***************************************************
   always_comb
   begin
      next_state = state;
      next_step  = step;
      next_sp    = sp_acc;
      next_soak  = soak_cnt;
      next_pre   = tenth_tick ? pre_cnt + 16'h0001 : pre_cnt;
      next_run   = run;
      nvm_evt    = 1'b0;
      if (!program_en)
      begin
         next_state = st_ready;
         next_step  = '0;
         if (wr_mode)
            next_run = pwdata[0];
         if (wr_cfg && new_type[1])
            next_run = 1'b0; // [RL18]
         if (ramp_off || cur_rate == 16'h0000)
            next_sp = tgt_fine; // [RL7] [RL25]
         else if (ramp_tick)
         begin
            next_sp  = ramp_next;
            next_pre = '0;
         end
      end
      else if (wr_restore)
      begin
         next_pre  = '0;
         next_soak = '0;
         if (ramp_type_setting == 2'h2)
         begin
            next_run   = 1'b0; // [RL13]
            next_state = st_ready;
            next_step  = '0;
         end
         else if (nvm_sync[4])
         begin
            next_run  = 1'b1;
            next_step = nvm_sync[2:0];
            if (nvm_sync[3] || alarm_sync)
               next_state = st_soak; // [RL14] [RL16]
            else
            begin
               next_state = st_ramp;
               next_sp    = to_fine(process_value); // [RL15]
            end
         end
      end
      else if (!run || (wr_mode && !pwdata[0]))
      begin
         next_run   = 1'b0;
         next_state = st_ready; // [RL10]
         next_step  = '0;
         if (!run && wr_mode && pwdata[0])
         begin
            next_run   = 1'b1;
            next_state = st_ramp;
            next_pre   = '0;
            nvm_evt    = 1'b1;
         end
      end
      else
      begin
         case (state)
            st_ramp:
               if (ramp_off || cur_rate == 16'h0000 || sp_acc == tgt_fine)
               begin
                  next_sp    = tgt_fine; // [RL7] [RL25]
                  next_state = st_soak; // [RL9]
                  next_soak  = '0;
                  next_pre   = '0;
                  nvm_evt    = 1'b1;
               end
               else if (ramp_tick)
               begin
                  next_sp  = ramp_next; // [RL9]
                  next_pre = '0;
               end
            st_soak:
            begin
               next_sp = tgt_fine; // [RL9]
               if (soak_cnt >= cur_soak)
               begin
                  next_pre = '0;
                  nvm_evt  = 1'b1;
                  if (!last_step)
                  begin
                     next_step  = step + 3'h1; // [RL24]
                     next_state = st_ramp;
                  end
                  else if (program_end_action == 2'h0)
                  begin
                     next_run   = 1'b0; // [RL23]
                     next_state = st_ready;
                     next_step  = '0;
                  end
                  else if (program_end_action == 2'h1)
                  begin
                     next_step  = '0; // [RL23]
                     next_state = st_ramp;
                  end
                  else
                     next_state = st_hold; // [RL23]
               end
               else if (soak_tick)
               begin
                  next_soak = soak_cnt + 16'h0001;
                  next_pre  = '0;
               end
            end
            st_hold:
               next_sp = tgt_fine;
            default:
               next_state = st_ramp;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state    <= st_ready;
         step     <= '0;
         sp_acc   <= '0;
         soak_cnt <= '0;
         pre_cnt  <= '0;
         run      <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         step     <= next_step;
         sp_acc   <= next_sp;
         soak_cnt <= next_soak;
         pre_cnt  <= next_pre;
         run      <= next_run;
      end
   end

   // ***************************************************
   // outputs, synchronisers, time base
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         working_setpoint <= '0;
         active_gain_set  <= `GAIN_RESET;
         remote_select    <= 1'b0;
         nvm_write        <= 1'b0;
         nvm_step         <= '0;
         nvm_soak         <= 1'b0;
         prdata           <= '0;
         tenth_cnt        <= '0;
         contact_meta     <= '0;
         contact_sync     <= '0;
         alarm_meta       <= 1'b0;
         alarm_sync       <= 1'b0;
         nvm_meta         <= '0;
         nvm_sync         <= '0;
      end
      else
      begin
         working_setpoint <= out_sp; // [RL1]
         active_gain_set  <= program_en ? step_gain[next_step] : `GAIN_RESET;
         remote_select    <= remote_request && !program_en; // [RL19]
         nvm_write        <= nvm_evt && ramp_type_setting == 2'h3; // [RL17]
         nvm_step         <= nvm_evt ? next_step : nvm_step;
         nvm_soak         <= nvm_evt ? (next_state == st_soak) : nvm_soak;
         tenth_cnt        <= tenth_tick ? '0 : tenth_cnt + 32'h1;
         contact_meta     <= contact_input;
         contact_sync     <= contact_meta;
         alarm_meta       <= input_alarm;
         alarm_sync       <= alarm_meta;
         nvm_meta         <= {nvm_saved_running, nvm_saved_soak, nvm_saved_step};
         nvm_sync         <= nvm_meta;
         if (setup_rd)
            prdata <= rd_mux;
      end
   end

   assign rd_mux =
      (paddr == `OFS_MODE)      ? {29'h0, remote_select, remote_request, run} :
      (paddr == `OFS_RANGE)     ? {24'h0, input_range_type} :
      (paddr == `OFS_SP_LOW)    ? {16'h0, sp_low} :
      (paddr == `OFS_SP_HIGH)   ? {16'h0, sp_high} :
      (paddr == `OFS_CONFIG)    ? {20'h0, step_count_setting, program_end_action, soak_time_unit,
                                   ramp_unit_setting, ramp_type_setting} :
      (paddr == `OFS_CONTACT)   ? {7'h0, contact_fn[4], contact_fn[3], contact_fn[2],
                                   contact_fn[1], contact_fn[0]} :
      (paddr == `OFS_STATUS)    ? {25'h0, ramp_off, run, state, step} :
      (paddr == `OFS_WORKING)   ? {{12{working_setpoint[19]}}, working_setpoint} :
      (paddr == `OFS_LOCAL_SP)  ? {16'h0, local_sp} :
      (paddr == `OFS_RAMP_RATE) ? {16'h0, ramp_rate} :
      (in_steps && wsel_field == 2'h0) ? {16'h0, step_target[wsel_step]} :
      (in_steps && wsel_field == 2'h1) ? {16'h0, step_rate[wsel_step]} :
      (in_steps && wsel_field == 2'h2) ? {16'h0, step_soak[wsel_step]} :
      (in_steps)                       ? {28'h0, step_gain[wsel_step]} : 32'h0;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sp_in_limits: assert property ($past(presetn) |-> working_setpoint >= $past(lo_f) // [RL1]
                                    && working_setpoint <= $past(hi_f))
      else $error("working setpoint outside limits");
   a_limits_ordered: assert property (sp_low > sp_high |-> lo == sp_high && hi == sp_low) // [RL2]
      else $error("limit pair not swapped");
   a_range_reload: assert property (wr_range |=> sp_low == $past(range_low) // [RL3]
                                    && sp_high == $past(range_high))
      else $error("limits not reloaded from range");
   a_contact_block: assert property ((fn_ramp != 5'h00 && (fn_ramp & ~contact_input) == 5'h00) [*3] // [RL5]
                                     |-> ramp_off)
      else $error("ramp not disabled by contact");
   a_disable_jump: assert property (run && program_en && state == st_ramp && ramp_off // [RL7]
                                    && !any_wr |=> sp_acc == $past(tgt_fine) && state == st_soak)
      else $error("ramp not halted at target");
   a_ready_step1: assert property (program_en && !run && !any_wr |=> step == 3'h0 // [RL10]
                                   && state == st_ready)
      else $error("ready mode not at step one");
   a_zero_rate: assert property (program_en && run && state == st_ramp && cur_rate == 16'h0000 // [RL25]
                                 && !any_wr |=> state == st_soak)
      else $error("zero rate ramp did not complete");
   a_type2_restore: assert property (wr_restore && program_en && ramp_type_setting == 2'h2 // [RL13]
                                     |=> !run && step == 3'h0)
      else $error("type 2 restore not ready");
   a_nvm_store: assert property (nvm_write |-> $past(nvm_evt) && $past(ramp_type_setting) == 2'h3) // [RL17]
      else $error("store without phase change");
   a_prog_switch: assert property (run && !program_en && wr_cfg && new_type[1] |=> !run) // [RL18]
      else $error("run kept on switch to program");
   a_local_forced: assert property (program_en |=> !remote_select) // [RL19]
      else $error("remote selected during program");

   c_soak: cover property (state == st_ramp ##1 state == st_soak);
   c_hold: cover property (state == st_hold);
   c_store: cover property (nvm_write);
   c_restore: cover property (wr_restore && ramp_type_setting == 2'h3);

endmodule

// ==== verification/setpoint_step_sequencer_test.sv ====
`timescale 1ns/1ns
`include "setpoint_consts.svh"
module setpoint_step_sequencer_test import setpoint_pkg::*;;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, remote_select, nvm_write, nvm_soak, saved_run = 1;
   logic        alarm = 0, saved_soak = 0;
   logic [4:0]  contact_input = 0;
   logic [3:0]  active_gain_set;
   logic [2:0]  nvm_step, saved_step = 0;
   sp_t         process_value = 0, range_low = 0, range_high = 0;
   sp_fine_t    working_setpoint;
   logic [32:0] exp_q[$], nvm_q[$];
   int          err_total = 0, cmp_count = 0, nvm_n = 0;
   logic [31:0] seed = 32'd46731;

   always #25 pclk = ~pclk;

   setpoint_step_sequencer #(.TENTH_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .process_value(process_value), .range_low(range_low), .range_high(range_high),
      .contact_input(contact_input), .input_alarm(alarm), .nvm_saved_running(saved_run),
      .nvm_saved_step(saved_step), .nvm_saved_soak(saved_soak), .working_setpoint(working_setpoint),
      .active_gain_set(active_gain_set), .remote_select(remote_select), .nvm_write(nvm_write),
      .nvm_step(nvm_step), .nvm_soak(nvm_soak));

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   // held until pready is seen high, then released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er = 1'b0);
      exp_q.push_back({er, e});
      xfer(1'b0, a, rnd());
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // bounded: a missing step change shows up in the gain or working compare after it
   task automatic wait_gain(input logic [3:0] g);
      for (int n = 0; n < 400 && active_gain_set !== g; n++) @(posedge pclk);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
         chk("prdata", exp_q.pop_front(), {pslverr, prdata});

   // only the first store after a noted restore is compared
   always @(posedge pclk)
      if (nvm_write === 1'b1)
      begin
         nvm_n++;
         if (nvm_q.size() > 0)
            chk("nvm", nvm_q.pop_front(), 33'({nvm_step, nvm_soak}));
      end

   always @(posedge pclk) process_value <= sp_t'(rnd() & 32'h3FF);

   initial
   begin
      #250000;
      err_total++;
      conclude();
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      logic [15:0] lo;
      logic [31:0] tab [8] = '{32'h96, 32'h0, 32'h2, 32'h3, 32'h78, 32'h0, 32'h0, 32'h5};
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rd(`OFS_CONFIG, 32'h104);
      rd(`OFS_CONTACT, 32'h0);
      rd(12'h03C, 32'h0, 1'b1);
      lo = 16'(rnd() & 32'h3FF);
      range_low <= lo;
      range_high <= lo + 16'h200;
      wr(`OFS_RANGE, 32'h3);
      rd(`OFS_SP_LOW, {16'h0, lo});
      rd(`OFS_SP_HIGH, {16'h0, lo + 16'h200});
      wr(`OFS_RAMP_RATE, 32'h0);
      wr(`OFS_SP_LOW, 32'h64);
      wr(`OFS_SP_HIGH, 32'hC8);
      wr(`OFS_LOCAL_SP, 32'h1F4);
      idle(4);
      rd(`OFS_WORKING, 32'h7D0);
      wr(`OFS_SP_LOW, 32'h12C);
      wr(`OFS_LOCAL_SP, 32'h190);
      idle(4);
      rd(`OFS_WORKING, 32'hBB8);
      // slow ramp so only the contact can bring the jump in time
      wr(`OFS_CONTACT, 32'h3400);
      wr(`OFS_RAMP_RATE, 32'h1);
      wr(`OFS_LOCAL_SP, 32'hC8);
      contact_input <= 5'h04;
      idle(8);
      chk("working", 33'd2000, 33'(working_setpoint));
      contact_input <= 5'h00;
      wr(`OFS_MODE, 32'h2);
      idle(3);
      chk("remote", 33'd1, 33'(remote_select));
      wr(`OFS_CONFIG, 32'h106);
      idle(3);
      chk("remote", 33'd0, 33'(remote_select));
      wr(`OFS_CONFIG, 32'h104);
      wr(`OFS_MODE, 32'h1);
      wr(`OFS_CONFIG, 32'h106);
      rd(`OFS_MODE, 32'h0);
      wr(`OFS_SP_LOW, 32'h0);
      for (int i = 0; i < 8; i++) wr(`OFS_STEP_BASE + 12'(i * 4), tab[i]);
      wr(`OFS_CONFIG, 32'h206);
      wr(`OFS_MODE, 32'h1);
      wait_gain(4'h3);
      chk("gain", 33'd3, 33'(active_gain_set));
      wait_gain(4'h5);
      idle(2);
      chk("working", 33'd1200, 33'(working_setpoint));
      idle(60);
      rd(`OFS_MODE, 32'h0);
      wr(`OFS_CONFIG, 32'h246);
      wr(`OFS_MODE, 32'h1);
      idle(60);
      rd(`OFS_MODE, 32'h1);
      wr(`OFS_RESTORE, 32'h1);
      rd(`OFS_MODE, 32'h0);
      saved_step <= 3'h1;
      saved_soak <= 1'b1;
      wr(`OFS_CONFIG, 32'h247);
      chk("nvm_n", 33'd0, 33'(nvm_n));
      nvm_q.push_back(33'h0);
      wr(`OFS_RESTORE, 32'h1);
      rd(`OFS_MODE, 32'h1);
      saved_soak <= 1'b0;
      wr(`OFS_MODE, 32'h0);
      idle(2);
      nvm_q.push_back(33'h3);
      wr(`OFS_RESTORE, 32'h1);
      alarm <= 1'b1;
      wr(`OFS_MODE, 32'h0);
      idle(2);
      nvm_q.push_back(33'h0);
      wr(`OFS_RESTORE, 32'h1);
      idle(2);
      chk("nvm_q", 33'd0, 33'(nvm_q.size()));
      conclude();
   end
endmodule
